// File: ach_checker.sv
// Port-level assertions for the acquisition command handler
module ach_checker
    import ach_pkg::*;
#(
    parameter int SRAM_AW = 18,
    parameter int SRAM_DW = 32
) (
    input wire logic               clk_sys,
    input wire logic               rst_b,
    input wire logic               clk_en,
    input wire logic               cmd_valid,
    input wire ach_msg_t           cmd_msg,
    input wire logic               cmd_ready,
    input wire logic               rsp_valid,
    input wire ach_msg_t           rsp_msg,
    input wire logic [31:0]        trig_enable,
    input wire logic [7:0]         tdc_cmd,
    input wire logic               tdc_reset,
    input wire logic               tdc_calib,
    input wire logic               tdc_run,
    input wire logic               sram_we,
    input wire logic               sram_re,
    input wire logic [SRAM_AW-1:0] sram_addr,
    input wire logic [SRAM_DW-1:0] sram_wdata
);
    logic               take;
    logic [3:0]         act_in;
    logic [7:0]         tdc_in;
    logic [SRAM_AW-1:0] pay_lo;
    assign take   = clk_en && cmd_valid && cmd_ready;
    assign act_in = cmd_msg.payload[3:0];
    assign tdc_in = cmd_msg.payload[7:0];
    assign pay_lo = cmd_msg.payload[SRAM_AW-1:0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Replies
    a_reply_two_edges: assert property (take && cmd_msg.id inside {16'h0006, 16'h0007, 16'h0008,
        16'h0009, 16'h000A, 16'h000B, 16'h0101, 16'h0102} |-> ##2 rsp_valid
        && rsp_msg.id == ($past(cmd_msg.id, 2) | 16'h8000)) else $error("reply late or bad id");
    a_unknown_error: assert property (take && !(cmd_msg.id inside {16'h0006, 16'h0007,
        16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h000F, 16'h0101,
        16'h0102, 16'h0103, 16'h0104}) |-> ##2 rsp_valid
        && rsp_msg == {16'hFF04, 32'h0}) else $error("unknown id not refused");
    a_reply_single: assert property (rsp_valid |=> !rsp_valid)
        else $error("reply strobe too long");
    a_action_clamp: assert property (take && cmd_msg.id == 16'h0007 |-> ##2
        rsp_msg.payload == (($past(act_in, 2) > 4'h2) ? 32'h2 : {28'h0, $past(act_in, 2)}))
        else $error("action reply not clamped");
    a_mask_store: assert property (take && cmd_msg.id == 16'h0009 |-> ##2
        trig_enable == $past(cmd_msg.payload, 2)) else $error("trigger mask not stored");
    a_tdc_load: assert property (take && cmd_msg.id == 16'h0101 |-> ##2
        tdc_cmd == $past(tdc_in, 2) ##1 (tdc_reset == (tdc_cmd == 8'h80)
        && tdc_calib == (tdc_cmd == 8'h02) && tdc_run == (tdc_cmd == 8'h04)))
        else $error("tdc command wrong");

    // ==========================================================
    // SRAM access
    a_sram_write: assert property (take && cmd_msg.id == 16'h000B |=> sram_we
        && sram_wdata == $past(cmd_msg.payload)) else $error("sram write data wrong");
    a_sram_step: assert property ((take && cmd_msg.id == 16'h000B) ##1 sram_we
        |=> sram_addr == $past(sram_addr) + 1'b1) else $error("sram address not advanced");
    a_sram_read_addr: assert property (take && cmd_msg.id == 16'h000C |=> sram_re
        && sram_addr == $past(pay_lo)) else $error("sram read address wrong");

    c_clear: cover property (take && cmd_msg.id == 16'h000D);
    c_adc_bcast: cover property (take && cmd_msg.id == 16'h0104 && cmd_msg.payload[31]);
    c_unknown: cover property (rsp_valid && rsp_msg.id == 16'hFF04);
endmodule : ach_checker

bind ach_command_handler ach_checker #(.SRAM_AW(SRAM_AW), .SRAM_DW(SRAM_DW)) ach_checker_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_msg(cmd_msg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_msg(rsp_msg),
    .trig_enable(trig_enable), .tdc_cmd(tdc_cmd), .tdc_reset(tdc_reset),
    .tdc_calib(tdc_calib), .tdc_run(tdc_run), .sram_we(sram_we), .sram_re(sram_re),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata));

// File: ach_command_handler.sv
// Command handler of the front_end_board node: executes parent commands and replies
//
// Operation
// - A too-large written action code is stored clamped and the clamped value replied.
// - Command 0x0006 replies with the stored acquisition settings word, payload ignored.
// - Command 0x0007 stores payload bits 3:0 as the acquisition action.
// - Action 0x0 resets mode and settings, 0x1 stops, 0x2 runs.
// - Command 0x0008 replies with the stored action code, as clamped on write.
// - Command 0x0009 stores a 32-bit per-channel trigger enable mask.
// - Command 0x000A replies with the stored trigger mask.
// - Command 0x000B writes payload to SRAM at current address, then increments.
// - Command 0x000C reads SRAM at payload address, replies word, increments address.
// - Command 0x000D zeroes the whole SRAM regardless of payload.
// - Command 0x000F returns all settings and peripherals to defaults.
// - Command 0x0101 loads payload bits 7:0 into the Time_converter_control.
// - TDC codes: 0x80 reset, 0x02 calibrate, 0x04 run.
// - Command 0x0102 replies with the Time_converter_control contents.
// - Command 0x0103 reprograms all ADC chips to default configuration.
// - Command 0x0104 writes 16-bit data to ADC register 25:18 on chip bit 27.
// - Payload bit 31 set makes the ADC write go to every chip.
// - Every reply carries the command ID, or the error code for unknown IDs, with MSB set plus 32-bit payload.
// - Unknown command IDs are answered with error code 0x7F04.
`include "ach_consts.svh"

module ach_command_handler
    import ach_pkg::*;
#(
    parameter int SRAM_AW  = 18,
    parameter int SRAM_DW  = 32,
    parameter int SRAM_LAT = 2
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    // Command from the parent, one-cycle strobe
    input  wire logic                 cmd_valid,
    input  wire ach_msg_t             cmd_msg,
    output logic                      cmd_ready,
    // Reply towards the parent
    output logic                      rsp_valid,
    output ach_msg_t                  rsp_msg,
    // Acquisition settings word kept by the mode logic
    input  wire logic [31:0]          acq_settings,
    output logic                      acq_reset,
    output logic                      acq_stop,
    output logic                      acq_run,
    output logic [31:0]               trig_enable,
    output logic                      tdc_reset,
    output logic                      tdc_calib,
    output logic                      tdc_run,
    output logic [7:0]                tdc_cmd,
    output logic                      sys_reset,
    // External SRAM
    output logic                      sram_we,
    output logic                      sram_re,
    output logic [SRAM_AW-1:0]        sram_addr,
    output logic [SRAM_DW-1:0]        sram_wdata,
    input  wire logic [SRAM_DW-1:0]   sram_rdata,
    // ADC register writes, one chip-select line per chip
    output logic                      adc_wr,
    output logic [1:0]                adc_cs,
    output ach_adc_wr_t               adc_req,
    output logic                      adc_defaults,
    input  wire logic                 adc_done
);

    // ==========================================================
    // State
    typedef struct packed {
        ach_state_t          state;
        logic [15:0]         id;
        logic [31:0]         rsp_data;
        logic                rsp_valid;
        logic [3:0]          action;
        logic [31:0]         trig_mask;
        logic [7:0]          tdc;
        logic [SRAM_AW-1:0]  addr;
        logic [SRAM_AW-1:0]  clr_addr;
        logic [7:0]          wait_cnt;
        logic                sram_we;
        logic                sram_re;
        logic [SRAM_DW-1:0]  wdata;
        logic                adc_wr;
        logic                adc_def;
        ach_adc_wr_t         adc;
        logic                sys_rst;
        logic                act_pulse;
    } ach_regs_t;

    ach_regs_t cur_ff;
    ach_regs_t nxt_cur;

    localparam logic [SRAM_AW-1:0] ADDR_LAST = {SRAM_AW{1'b1}};
    localparam logic [7:0]         RD_WAIT   = 8'(SRAM_LAT);

    function automatic logic [3:0] clamp_action(input logic [3:0] code);
        clamp_action = (code > `ACH_ACT_MAX) ? `ACH_ACT_MAX : code;
    endfunction : clamp_action

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt_cur           = cur_ff;
        nxt_cur.rsp_valid = 1'b0;
        nxt_cur.sram_we   = 1'b0;
        nxt_cur.sram_re   = 1'b0;
        nxt_cur.adc_wr    = 1'b0;
        nxt_cur.adc_def   = 1'b0;
        nxt_cur.sys_rst   = 1'b0;
        nxt_cur.act_pulse = 1'b0;
        unique case (cur_ff.state)
            ACH_IDLE: begin
                if (cmd_valid) begin
                    nxt_cur.id       = cmd_msg.id;
                    nxt_cur.rsp_data = 32'h0000_0000;
                    nxt_cur.state    = ACH_REPLY;
                    unique case (cmd_msg.id)
                        `ACH_CMD_RD_SETTINGS: begin
                            nxt_cur.rsp_data = acq_settings;
                        end
                        `ACH_CMD_WR_ACTION: begin
                            nxt_cur.action    = clamp_action(cmd_msg.payload[3:0]);
                            nxt_cur.act_pulse = 1'b1;
                            nxt_cur.rsp_data  = {28'h0, clamp_action(cmd_msg.payload[3:0])};
                        end
                        `ACH_CMD_RD_ACTION: begin
                            nxt_cur.rsp_data = {28'h0, cur_ff.action};
                        end
                        `ACH_CMD_WR_TRIG_MASK: begin
                            nxt_cur.trig_mask = cmd_msg.payload;
                            nxt_cur.rsp_data  = cmd_msg.payload;
                        end
                        `ACH_CMD_RD_TRIG_MASK: begin
                            nxt_cur.rsp_data = cur_ff.trig_mask;
                        end
                        `ACH_CMD_WR_SRAM: begin
                            nxt_cur.sram_we  = 1'b1;
                            nxt_cur.wdata    = cmd_msg.payload[SRAM_DW-1:0];
                            nxt_cur.rsp_data = cmd_msg.payload;
                        end
                        `ACH_CMD_RD_SRAM: begin
                            nxt_cur.addr     = cmd_msg.payload[SRAM_AW-1:0];
                            nxt_cur.sram_re  = 1'b1;
                            nxt_cur.wait_cnt = RD_WAIT;
                            nxt_cur.state    = ACH_SRAM;
                        end
                        `ACH_CMD_CLR_SRAM: begin
                            nxt_cur.clr_addr = '0;
                            nxt_cur.wdata    = '0;
                            nxt_cur.state    = ACH_CLEAR;
                        end
                        `ACH_CMD_SYS_RESET: begin
                            nxt_cur.sys_rst   = 1'b1;
                            nxt_cur.action    = `ACH_RST_ACTION;
                            nxt_cur.act_pulse = 1'b1;
                            nxt_cur.trig_mask = `ACH_RST_TRIG_MASK;
                            nxt_cur.tdc       = `ACH_RST_TDC;
                            nxt_cur.addr      = '0;
                            nxt_cur.adc_def   = 1'b1;
                            nxt_cur.state     = ACH_ADC;
                        end
                        `ACH_CMD_WR_TDC: begin
                            nxt_cur.tdc      = cmd_msg.payload[7:0];
                            nxt_cur.rsp_data = {24'h0, cmd_msg.payload[7:0]};
                        end
                        `ACH_CMD_RD_TDC: begin
                            nxt_cur.rsp_data = {24'h0, cur_ff.tdc};
                        end
                        `ACH_CMD_ADC_DEFAULT: begin
                            nxt_cur.adc_def = 1'b1;
                            nxt_cur.state   = ACH_ADC;
                        end
                        `ACH_CMD_ADC_WRITE: begin
                            nxt_cur.adc.data     = cmd_msg.payload[`ACH_ADC_DATA_MSB:0];
                            nxt_cur.adc.addr     =
                                cmd_msg.payload[`ACH_ADC_ADDR_MSB:`ACH_ADC_ADDR_LSB];
                            nxt_cur.adc.chip_sel = cmd_msg.payload[`ACH_ADC_CHIP_BIT];
                            nxt_cur.adc.bcast    = cmd_msg.payload[`ACH_ADC_BCAST_BIT];
                            nxt_cur.adc_wr       = 1'b1;
                            nxt_cur.state        = ACH_ADC;
                        end
                        default: begin
                            nxt_cur.id = `ACH_ERR_UNKNOWN;
                        end
                    endcase
                end
            end
            ACH_SRAM: begin
                // Fixed read latency; the data bus is sampled once it has settled
                if (cur_ff.wait_cnt == 8'h00) begin
                    nxt_cur.rsp_data = 32'(sram_rdata);
                    nxt_cur.addr     = cur_ff.addr + 1'b1;
                    nxt_cur.state    = ACH_REPLY;
                end else begin
                    nxt_cur.wait_cnt = cur_ff.wait_cnt - 8'h01;
                end
            end
            ACH_CLEAR: begin
                nxt_cur.sram_we  = 1'b1;
                nxt_cur.clr_addr = cur_ff.clr_addr + 1'b1;
                if (cur_ff.clr_addr == ADDR_LAST) begin
                    nxt_cur.addr  = '0;
                    nxt_cur.state = ACH_REPLY;
                end
            end
            ACH_ADC: begin
                // The ADC serial engine owns timing; wait for its completion
                if (adc_done) begin
                    nxt_cur.state = ACH_REPLY;
                end
            end
            ACH_REPLY: begin
                nxt_cur.rsp_valid = 1'b1;
                nxt_cur.state     = ACH_IDLE;
            end
            default: begin
                nxt_cur.state = ACH_IDLE;
            end
        endcase
        // Post-increment in the cycle after the write strobe; clear leaves the pointer at zero
        if (cur_ff.sram_we && cur_ff.id == `ACH_CMD_WR_SRAM) begin
            nxt_cur.addr = cur_ff.addr + 1'b1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cur_ff           <= '0;
            cur_ff.state     <= ACH_IDLE;
            cur_ff.action    <= `ACH_RST_ACTION;
            cur_ff.trig_mask <= `ACH_RST_TRIG_MASK;
            cur_ff.tdc       <= `ACH_RST_TDC;
        end else if (clk_en) begin
            cur_ff <= nxt_cur;
        end
    end

    // ==========================================================
    // Outputs
    assign cmd_ready     = (cur_ff.state == ACH_IDLE);
    assign rsp_valid     = cur_ff.rsp_valid;
    assign rsp_msg.id    = cur_ff.id | `ACH_REPLY_FLAG;
    assign rsp_msg.payload = cur_ff.rsp_data;

    // Action decode; reset and stop pulse only on an action write or 0x000F so mode logic sees one event, run is a level
    assign acq_reset = cur_ff.act_pulse && (cur_ff.action == `ACH_ACT_RESET);
    assign acq_stop  = cur_ff.act_pulse && (cur_ff.action == `ACH_ACT_STOP);
    assign acq_run   = (cur_ff.action == `ACH_ACT_RUN);

    assign trig_enable = cur_ff.trig_mask;
    assign tdc_cmd     = cur_ff.tdc;
    assign tdc_reset   = (cur_ff.tdc == `ACH_TDC_RESET);
    assign tdc_calib   = (cur_ff.tdc == `ACH_TDC_CALIB);
    assign tdc_run     = (cur_ff.tdc == `ACH_TDC_RUN);
    assign sys_reset   = cur_ff.sys_rst;

    // SRAM write address is the clear pointer while zeroing
    assign sram_we    = cur_ff.sram_we;
    assign sram_re    = cur_ff.sram_re;
    assign sram_addr  = (cur_ff.state == ACH_CLEAR) ? cur_ff.clr_addr : cur_ff.addr;
    assign sram_wdata = (cur_ff.state == ACH_CLEAR) ? '0 : cur_ff.wdata;

    assign adc_wr       = cur_ff.adc_wr;
    assign adc_req      = cur_ff.adc;
    assign adc_defaults = cur_ff.adc_def;
    assign adc_cs[0]    = cur_ff.adc.bcast || !cur_ff.adc.chip_sel;
    assign adc_cs[1]    = cur_ff.adc.bcast || cur_ff.adc.chip_sel;

endmodule : ach_command_handler

// File: ach_command_handler_test.sv
// Self-checking bench of the acquisition command handler
module ach_command_handler_test;
    import ach_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 2;
    typedef struct packed {logic [15:0] id; logic [31:0] pay; logic [47:0] exp;} ach_row_t;
    logic clk_sys = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, sram_we, sram_re, adc_wr, adc_done;
    logic cmd_ready, rsp_valid, acq_run, adc_defaults;
    logic [1:0] adc_cs, cs_seen;
    ach_msg_t cmd_msg = '0, rsp_msg, r;
    ach_adc_wr_t adc_req, adc_seen;
    logic [3:0] sram_addr;
    logic [31:0] sram_wdata, sram_rdata, trig_enable;
    int error_cnt = 0, total_checks = 0;
    ach_row_t rows [27] = '{
        '{16'h0009, 32'h0000_0121, 48'h8009_0000_0121},
        '{16'h000A, 32'hDEAD_FEED, 48'h800A_0000_0121},
        '{16'h0007, 32'hFFFF_FFF1, 48'h8007_0000_0001},
        '{16'h0008, 32'hDEAD_FEED, 48'h8008_0000_0001},
        '{16'h0007, 32'h0000_000F, 48'h8007_0000_0002},
        '{16'h0008, 32'h0000_0000, 48'h8008_0000_0002},
        '{16'h0101, 32'hFFFF_FF80, 48'h8101_0000_0080},
        '{16'h0102, 32'hDEAD_FEED, 48'h8102_0000_0080},
        '{16'h0101, 32'h0000_0002, 48'h8101_0000_0002},
        '{16'h0101, 32'h0000_0004, 48'h8101_0000_0004},
        '{16'h0102, 32'h0000_0000, 48'h8102_0000_0004},
        '{16'h0006, 32'hDEAD_FEED, 48'h8006_0200_0101},
        '{16'h0055, 32'h0000_0000, 48'hFF04_0000_0000},
        '{16'h0007, 32'h0000_0000, 48'h8007_0000_0000},
        '{16'h000C, 32'h0000_0005, 48'h800C_FFFF_FFFF},
        '{16'h000D, 32'hDEAD_FEED, 48'h800D_0000_0000},
        '{16'h000C, 32'h0000_0005, 48'h800C_0000_0000},
        '{16'h000B, 32'hAAAA_5555, 48'h800B_AAAA_5555},
        '{16'h000B, 32'h5555_AAAA, 48'h800B_5555_AAAA},
        '{16'h000C, 32'h0000_0006, 48'h800C_AAAA_5555},
        '{16'h000B, 32'h0123_4567, 48'h800B_0123_4567},
        '{16'h000C, 32'h0000_0007, 48'h800C_0123_4567},
        '{16'h0103, 32'hDEAD_FEED, 48'h8103_0000_0000},
        '{16'h000F, 32'h0000_0000, 48'h800F_0000_0000},
        '{16'h000A, 32'hDEAD_FEED, 48'h800A_0000_0000},
        '{16'h0008, 32'hDEAD_FEED, 48'h8008_0000_0000},
        '{16'h0102, 32'hDEAD_FEED, 48'h8102_0000_0000}};

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (adc_wr === 1'b1) {adc_seen, cs_seen} = {adc_req, adc_cs};

    ach_command_handler #(.SRAM_AW(4)) ach_command_handler_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1), .cmd_valid(cmd_valid),
        .cmd_msg(cmd_msg), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_msg(rsp_msg),
        .acq_settings(32'h0200_0101), .acq_reset(), .acq_stop(), .acq_run(acq_run),
        .trig_enable(trig_enable), .tdc_reset(), .tdc_calib(), .tdc_run(), .tdc_cmd(),
        .sys_reset(), .sram_we(sram_we), .sram_re(sram_re), .sram_addr(sram_addr),
        .sram_wdata(sram_wdata), .sram_rdata(sram_rdata), .adc_wr(adc_wr), .adc_cs(adc_cs),
        .adc_req(adc_req), .adc_defaults(adc_defaults), .adc_done(adc_done));
    ach_periph_model #(.AW(4)) ach_periph_model_inst (
        .clk_sys(clk_sys), .sram_we(sram_we), .sram_re(sram_re), .sram_addr(sram_addr),
        .sram_wdata(sram_wdata), .sram_rdata(sram_rdata), .adc_wr(adc_wr),
        .adc_defaults(adc_defaults), .adc_done(adc_done));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [49:0] seen, input logic [49:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Poke drives a second strobe while busy; it must leave no trace
    task automatic send(input logic [15:0] id, input logic [31:0] pay, input bit poke);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_msg = {id, pay};
        @(posedge clk_sys); #DLY;
        if (poke) begin
            cmd_msg = {16'h0009, 32'hFFFF_FFFF};
            @(posedge clk_sys); #DLY;
        end
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(posedge clk_sys); #DLY;
            n++;
        end
        if (n == 200) check("reply wait", 50'h1, 50'h0);
        r = rsp_msg;
    endtask : send

    task automatic give_verdict;
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        #DLY rst_b = 1'b1;
        foreach (rows[i]) begin
            send(rows[i].id, rows[i].pay, 1'b0);
            check("reply", {2'b0, r}, {2'b0, rows[i].exp});
        end
        send(16'h0007, 32'h2, 1'b0);
        check("acq_run", {49'h0, acq_run}, 50'h1);
        send(16'h0007, 32'h1, 1'b0);
        check("acq_run", {49'h0, acq_run}, 50'h0);
        send(16'h0007, 32'h0, 1'b0);
        adc_seen = '1;
        send(16'h0104, 32'h00AC_6666, 1'b0);
        check("adc", {adc_seen, cs_seen}, {1'b0, 1'b0, 8'h2B, 16'h6666, 2'b01});
        adc_seen = '1;
        send(16'h0104, 32'h88A8_8888, 1'b0);
        check("adc", {adc_seen, cs_seen}, {1'b1, 1'b1, 8'h2A, 16'h8888, 2'b11});
        send(16'h000D, 32'h0, 1'b1);
        send(16'h000A, 32'h0, 1'b0);
        check("mask", {2'b0, r}, {2'b0, 48'h800A_0000_0000});
        send(16'h0009, 32'hFFFF_0000, 1'b0);
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #DLY rst_b = 1'b1;
        check("mask", {17'h0, cmd_ready, trig_enable}, {17'h0, 1'b1, 32'h0});
        give_verdict();
    end
endmodule : ach_command_handler_test

// File: ach_consts.svh
// Command codes, field positions, reset values and limits of the acquisition command handler
`ifndef ACH_CONSTS_SVH
`define ACH_CONSTS_SVH

`define ACH_CMD_RD_SETTINGS  16'h0006
`define ACH_CMD_WR_ACTION    16'h0007
`define ACH_CMD_RD_ACTION    16'h0008
`define ACH_CMD_WR_TRIG_MASK 16'h0009
`define ACH_CMD_RD_TRIG_MASK 16'h000A
`define ACH_CMD_WR_SRAM      16'h000B
`define ACH_CMD_RD_SRAM      16'h000C
`define ACH_CMD_CLR_SRAM     16'h000D
`define ACH_CMD_SYS_RESET    16'h000F
`define ACH_CMD_WR_TDC       16'h0101
`define ACH_CMD_RD_TDC       16'h0102
`define ACH_CMD_ADC_DEFAULT  16'h0103
`define ACH_CMD_ADC_WRITE    16'h0104

`define ACH_ERR_UNKNOWN      16'h7F04
`define ACH_REPLY_FLAG       16'h8000

`define ACH_ACT_RESET        4'h0
`define ACH_ACT_STOP         4'h1
`define ACH_ACT_RUN          4'h2
`define ACH_ACT_MAX          4'h2

`define ACH_TDC_RESET        8'h80
`define ACH_TDC_CALIB        8'h02
`define ACH_TDC_RUN          8'h04

`define ACH_ADC_DATA_MSB     15
`define ACH_ADC_ADDR_MSB     25
`define ACH_ADC_ADDR_LSB     18
`define ACH_ADC_CHIP_BIT     27
`define ACH_ADC_BCAST_BIT    31

`define ACH_RST_ACTION       4'h0
`define ACH_RST_TRIG_MASK    32'h0000_0000
`define ACH_RST_TDC          8'h00
`define ACH_RST_SETTINGS     32'h0000_0000

`endif

// File: ach_periph_model.sv
// Behavioural external SRAM and ADC engine seen by the handler
module ach_periph_model #(
    parameter int AW       = 4,
    parameter int DW       = 32,
    parameter int DONE_DLY = 3
) (
    input wire logic          clk_sys,
    input wire logic          sram_we,
    input wire logic          sram_re,
    input wire logic [AW-1:0] sram_addr,
    input wire logic [DW-1:0] sram_wdata,
    output logic [DW-1:0]     sram_rdata,
    input wire logic          adc_wr,
    input wire logic          adc_defaults,
    output logic              adc_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DW-1:0] mem [2**AW];
    int            adc_cnt = 0;
    // Non-zero power-up contents so that a clear is visible
    initial for (int i = 0; i < 2**AW; i++) mem[i] = '1;
    initial sram_rdata = '0;
    initial adc_done = 1'b0;
    // ==========================================================
    // Read data holds until the next access; a write flips it so stale data never matches
    always @(posedge clk_sys) begin
        if (sram_we) begin
            mem[sram_addr] <= sram_wdata;
            sram_rdata <= ~sram_rdata;
        end else if (sram_re) begin
            sram_rdata <= mem[sram_addr];
        end
        if (adc_wr || adc_defaults) adc_cnt <= DONE_DLY;
        else if (adc_cnt != 0) adc_cnt <= adc_cnt - 1;
        adc_done <= (adc_cnt == 1);
    end
endmodule : ach_periph_model

// File: ach_pkg.sv
// Types shared by the acquisition command handler
package ach_pkg;

    typedef struct packed {
        logic [15:0] id;
        logic [31:0] payload;
    } ach_msg_t;

    typedef struct packed {
        logic        chip_sel;
        logic        bcast;
        logic [7:0]  addr;
        logic [15:0] data;
    } ach_adc_wr_t;

    typedef enum logic [2:0] {
        ACH_IDLE  = 3'b000,
        ACH_SRAM  = 3'b001,
        ACH_CLEAR = 3'b011,
        ACH_ADC   = 3'b010,
        ACH_REPLY = 3'b110
    } ach_state_t;

endpackage : ach_pkg
